// ### verilog/run_test_consts.vh
`ifndef RUN_TEST_CONSTS_VH
`define RUN_TEST_CONSTS_VH
// test control register layout
`define CTRL_WIDTH       11
`define CTRL_RESET       11'h000
`define CTRL_OP_HI       2
`define CTRL_OP_LO       0
`define CTRL_MASK_HI     10
`define CTRL_MASK_LO     3
// low two opcode bits, upper bit don't care
`define OP_SAMPLE_TOGGLE 2'h0
`define OP_PATTERN       2'h1
`define OP_SIGNATURE     2'h2
// full three-bit opcodes
`define OP_SIG_PATTERN   3'h3
`define OP_SIG_COUNT     3'h7
// feedback taps, bit i set means stage i feeds back
`define TAPS16_B_TO_A    16'hB400
`define TAPS16_A_TO_B    16'hD008
`define TAPS8_B_TO_A     8'hB8
`define TAPS8_A_TO_B     8'h8E
`define CELL_RESET       8'h00
`define SYNC_WIDTH       24
`endif

// ### verilog/boundary_run_test_engine.v
`include "run_test_consts.vh"
`default_nettype none

// Behaviour
// - control scan shifts; capture leaves contents unchanged
// - opcode taken from control bits two to zero
// - x00 sample/toggle, x01 16-bit pattern generation
// - x10 selects 16-bit signature of inputs
// - 011 selects 8-bit signature plus 8-bit pattern
// - 111 selects 8-bit signature plus binary count
// - run only with run instruction in idle
// - control cells excluded; enable cells still gate drive
// - run only when exactly one direction enabled
// - bits 10..3 mask source pins 7..0
// - mask one removes pin from signature
// - sample/toggle captures inputs, passes to core shadow
// - toggle outputs on rise, drive on fall
// - pattern advances on rise, driven and latched on fall
// - all-zero pattern seed stays locked at zero
// - signature compresses inputs, output shadows hold
// - combined signature and pattern, pattern driven on fall
// - count mode: opposite outputs count carries, 16 bits
// - sample on test clock rise, outputs change on fall
module boundary_run_test_engine (
	input  wire       clk,
	input  wire       rst_b,
	input  wire       tck,
	input  wire       tdi,
	input  wire       runSelectedTest,
	input  wire       tapIdle,
	input  wire       ctrlScanSelect,
	input  wire       captureDr,
	input  wire       shiftDr,
	input  wire       aSideDriveEnable_b,
	input  wire       bSideDriveEnable_b,
	input  wire [7:0] aPinIn,
	input  wire [7:0] bPinIn,
	input  wire       seedLoad,
	input  wire [7:0] seedAIn,
	input  wire [7:0] seedAOut,
	input  wire [7:0] seedBIn,
	input  wire [7:0] seedBOut,
	output reg        tdo,
	output reg  [7:0] aPinOut,
	output wire       aPinOutEn_b,
	output reg  [7:0] bPinOut,
	output wire       bPinOutEn_b,
	output reg  [7:0] coreAIn,
	output reg  [7:0] coreBIn,
	output wire [7:0] cellAIn,
	output wire [7:0] cellAOut,
	output wire [7:0] cellBIn,
	output wire [7:0] cellBOut,
	output wire [10:0] ctrlValue,
	output wire       testRunning
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers: every pin and tap-side level passes two flip-flops

reg                    tckSync1_q;
reg                    tckSync2_q;
reg                    tckPrev_q;
reg  [`SYNC_WIDTH-1:0] sync1_q;
reg  [`SYNC_WIDTH-1:0] sync2_q;
wire [`SYNC_WIDTH-1:0] rawIn;

// msb first: pins of both sides, then the enable and tap-side levels
assign rawIn = {
	aPinIn,
	bPinIn,
	bSideDriveEnable_b,
	aSideDriveEnable_b,
	shiftDr,
	captureDr,
	ctrlScanSelect,
	tapIdle,
	runSelectedTest,
	tdi
};

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		sync1_q <= {`SYNC_WIDTH{1'h0}};
		sync2_q <= {`SYNC_WIDTH{1'h0}};
	end else begin
		sync1_q <= rawIn;
		sync2_q <= sync1_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// test clock edges
// tck and the levels share one pipe depth, so tdi lines up with its rise
// tck must stay well under a third of the clk rate or edges are lost

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		tckSync1_q <= 1'h0;
		tckSync2_q <= 1'h0;
		tckPrev_q  <= 1'h0;
	end else begin
		tckSync1_q <= tck;
		tckSync2_q <= tckSync1_q;
		tckPrev_q  <= tckSync2_q;
	end
end

wire       tckRise = tckSync2_q & ~tckPrev_q;
wire       tckFall = ~tckSync2_q & tckPrev_q;
wire       tdiS    = sync2_q[0];
wire       runS    = sync2_q[1];
wire       idleS   = sync2_q[2];
wire       scanS   = sync2_q[3];
wire       shiftS  = sync2_q[5];
wire       oeAS    = sync2_q[6];
wire       oeBS    = sync2_q[7];
wire [7:0] bPinS   = sync2_q[15:8];
wire [7:0] aPinS   = sync2_q[23:16];

////////////////////////////////////////////////////////////////////////////////
// test control register, scanned lsb first out, tdi into msb

reg [`CTRL_WIDTH-1:0] ctrl_q;

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		ctrl_q <= `CTRL_RESET;
	end else if (tckRise && scanS && shiftS) begin
		ctrl_q <= {tdiS, ctrl_q[`CTRL_WIDTH-1:1]};
	end
end
// capture-dr is deliberately not decoded here, so contents stay put

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		tdo <= 1'b0;
	end else if (tckFall) begin
		tdo <= ctrl_q[0];
	end
end

assign ctrlValue = ctrl_q;

wire [2:0] opcode = ctrl_q[`CTRL_OP_HI:`CTRL_OP_LO];
wire [7:0] mask   = ctrl_q[`CTRL_MASK_HI:`CTRL_MASK_LO];
// only 011 and 111 reach the 8-bit branch, so one compare splits them
wire       opSigCount = (opcode == `OP_SIG_COUNT);

// a outputs off and b outputs on means data flows a to b
wire aToB     = oeAS & ~oeBS;
wire dirValid = oeAS ^ oeBS;
// with both or neither direction enabled the engine idles, as bypass does
wire run      = runS & idleS & dirValid;

assign testRunning = run;

////////////////////////////////////////////////////////////////////////////////
// feedback steps; an all-zero state maps to itself, no escape is built

function [15:0] step16;
	input [15:0] v;
	input        dir;
	reg   [15:0] taps;
	reg          fb;
	begin
		taps   = dir ? `TAPS16_A_TO_B : `TAPS16_B_TO_A;
		fb     = ^(v & taps);
		// shift towards the msb, feedback enters stage zero
		step16 = {v[14:0], fb};
	end
endfunction

function [7:0] step8;
	input [7:0] v;
	input       dir;
	reg   [7:0] taps;
	reg         fb;
	begin
		taps  = dir ? `TAPS8_A_TO_B : `TAPS8_B_TO_A;
		fb    = ^(v & taps);
		// same direction as the wide register, so seeds read alike
		step8 = {v[6:0], fb};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// boundary cells: shift stages and shadow latches per side

reg [7:0] aInCell_q;
reg [7:0] aOutCell_q;
reg [7:0] bInCell_q;
reg [7:0] bOutCell_q;
reg       driveOnFall_q;
reg       coreOnFall_q;

assign cellAIn  = aInCell_q;
assign cellAOut = aOutCell_q;
assign cellBIn  = bInCell_q;
assign cellBOut = bOutCell_q;

// source side: input cells; destination side: output cells
wire [7:0] srcIn   = aToB ? aInCell_q : bInCell_q;
wire [7:0] dstOut  = aToB ? bOutCell_q : aOutCell_q;
wire [7:0] oppOut  = aToB ? aOutCell_q : bOutCell_q;
wire [7:0] srcPins = aToB ? aPinS : bPinS;
wire [7:0] sigData;

// per pin: a set mask bit blanks that pin from the signature
genvar pin;
generate
	for (pin = 0; pin < 8; pin = pin + 1) begin : maskPin
		assign sigData[pin] = srcPins[pin] & ~mask[pin];
	end
endgenerate

reg [7:0]  nSrcIn;
reg [7:0]  nDstOut;
reg [7:0]  nOppOut;
reg [15:0] wide;
reg        drive;
reg        core;

always @* begin
	nSrcIn  = srcIn;
	nDstOut = dstOut;
	nOppOut = oppOut;
	wide    = {dstOut, srcIn};
	drive   = 1'b0;
	core    = 1'b1;
	case (opcode[1:0])
		`OP_SAMPLE_TOGGLE: begin
			nSrcIn  = srcPins;
			nDstOut = ~dstOut;
			drive   = 1'b1;
		end
		`OP_PATTERN: begin
			wide    = step16({dstOut, srcIn}, aToB);
			nDstOut = wide[15:8];
			nSrcIn  = wide[7:0];
			drive   = 1'b1;
		end
		`OP_SIGNATURE: begin
			wide    = step16({dstOut, srcIn}, aToB) ^ {8'h00, sigData};
			nDstOut = wide[15:8];
			nSrcIn  = wide[7:0];
		end
		default: begin
			nSrcIn = step8(srcIn, aToB) ^ sigData;
			drive  = 1'b1;
			if (opSigCount) begin
				nDstOut = dstOut + 8'h01;
				nOppOut = oppOut + {7'h00, &dstOut};
			end else begin
				nDstOut = step8(dstOut, aToB);
			end
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// fall qualifiers: only a fall that follows a running rise moves shadows

always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		driveOnFall_q <= 1'h0;
		coreOnFall_q  <= 1'h0;
	end else if (tckRise) begin
		driveOnFall_q <= run & drive;
		coreOnFall_q  <= run & core;
	end
end

// a side cells; rise steps them, the following fall moves shadows
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		aInCell_q  <= `CELL_RESET;
		aOutCell_q <= `CELL_RESET;
	end else if (seedLoad) begin
		aInCell_q  <= seedAIn;
		aOutCell_q <= seedAOut;
	end else if (tckRise && run) begin
		if (aToB) begin
			aInCell_q  <= nSrcIn;
			aOutCell_q <= nOppOut;
		end else begin
			aOutCell_q <= nDstOut;
		end
	end
end

// b side cells; a seed load wins over a step in the same cycle
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		bInCell_q  <= `CELL_RESET;
		bOutCell_q <= `CELL_RESET;
	end else if (seedLoad) begin
		bInCell_q  <= seedBIn;
		bOutCell_q <= seedBOut;
	end else if (tckRise && run) begin
		if (aToB) begin
			bOutCell_q <= nDstOut;
		end else begin
			bInCell_q  <= nSrcIn;
			bOutCell_q <= nOppOut;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// shadows

// output shadows drive the pins; signature mode leaves them holding
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		aPinOut <= `CELL_RESET;
		bPinOut <= `CELL_RESET;
	end else if (tckFall && driveOnFall_q) begin
		aPinOut <= aOutCell_q;
		bPinOut <= bOutCell_q;
	end
end

// input shadows feed the core after every running rise
always @(posedge clk or negedge rst_b) begin
	if (!rst_b) begin
		coreAIn <= `CELL_RESET;
		coreBIn <= `CELL_RESET;
	end else if (tckFall && coreOnFall_q) begin
		coreAIn <= aInCell_q;
		coreBIn <= bInCell_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// drive enables

// enable cells keep deciding drive or float during self
assign aPinOutEn_b = oeAS;
assign bPinOutEn_b = oeBS;

endmodule

`default_nettype wire

// ### verif/tap_model.sv
`default_nettype none
module tap_model (
	output logic tck,
	output logic tdi,
	output logic runSelectedTest,
	output logic tapIdle,
	output logic ctrlScanSelect,
	output logic captureDr,
	output logic shiftDr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {tck, tdi, runSelectedTest, tapIdle, ctrlScanSelect, captureDr, shiftDr} = 7'h00;
	// levels move only while tck is low, well clear of the rise
	task automatic tick(input logic b);
		tdi = b;
		#40 tck = 1'b1;
		#80 tck = 1'b0;
		#40;
	endtask
	// control loaded lsb first before any run; a capture follows
	task automatic load(input logic [10:0] v);
		{runSelectedTest, tapIdle, ctrlScanSelect, shiftDr} = 4'h3;
		for (int i = 0; i < 11; i++) tick(v[i]);
		{shiftDr, captureDr} = 2'h1;
		// inverted tdi exposes a capture that wrongly shifts
		tick(~v[0]);
		{ctrlScanSelect, captureDr} = 2'h0;
	endtask
	task automatic run(input logic idle);
		{runSelectedTest, tapIdle} = {1'b1, idle};
		tick(1'b0);
	endtask
endmodule
`default_nettype wire

// ### verif/boundary_run_test_engine_properties.sv
`default_nettype none
module boundary_run_test_engine_properties (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        tck,
	input wire logic        seedLoad,
	input wire logic        aPinOutEn_b,
	input wire logic        bPinOutEn_b,
	input wire logic        tdo,
	input wire logic [7:0]  aPinOut,
	input wire logic [7:0]  bPinOut,
	input wire logic [7:0]  coreAIn,
	input wire logic [7:0]  cellAIn,
	input wire logic [7:0]  cellAOut,
	input wire logic [7:0]  cellBIn,
	input wire logic [7:0]  cellBOut,
	input wire logic [10:0] ctrlValue,
	input wire logic        testRunning
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_run_one_dir: assert property (testRunning |-> aPinOutEn_b != bPinOutEn_b)
		else $error("run with both enables alike");
	a_cells_hold_idle: assert property (!testRunning && !seedLoad |=>
		$stable({cellAIn, cellAOut, cellBIn, cellBOut})) else $error("cells moved idle");
	a_pin_on_fall: assert property ($changed(bPinOut) |-> !tck && bPinOut == cellBOut)
		else $error("pin update off the fall");
	a_core_from_cell: assert property ($changed(coreAIn) |-> !tck && coreAIn == cellAIn)
		else $error("core shadow wrong");
	a_tdo_from_ctrl: assert property ($changed(tdo) |-> !tck && tdo == ctrlValue[0])
		else $error("tdo wrong");
	a_ctrl_on_rise: assert property ($changed(ctrlValue) |-> tck)
		else $error("control moved off a rise");
	a_sig_hold_out: assert property (ctrlValue[1:0] == 2'h2 && $past(ctrlValue[1:0]) == 2'h2
		|-> $stable(aPinOut) && $stable(bPinOut)) else $error("outputs moved");
	a_toggle_inverts: assert property ($changed(cellBOut) && ctrlValue[1:0] == 2'h0
		&& !$past(seedLoad) |-> cellBOut == ~$past(cellBOut)) else $error("no inversion");
endmodule
`default_nettype wire

// ### verif/testbench.sv
`include "run_test_consts.vh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rst_b = 1'b0, seedLoad = 1'b0, aSideDriveEnable_b = 1'b1;
	logic        bSideDriveEnable_b = 1'b0, ab;
	logic [7:0]  aPinIn = 8'h00, bPinIn = 8'h00, seedAIn, seedAOut, seedBIn, seedBOut;
	logic [7:0]  si, so, oo, pa = 8'h00, pb = 8'h00;
	logic [2:0]  op;
	logic [23:0] e;
	int          mismatches = 0, compares = 0;
	wire         tck, tdi, runSelectedTest, tapIdle, ctrlScanSelect, captureDr, shiftDr;
	wire         tdo, aPinOutEn_b, bPinOutEn_b, testRunning;
	wire [7:0]   aPinOut, bPinOut, coreAIn, coreBIn, cellAIn, cellAOut, cellBIn, cellBOut;
	wire [10:0]  ctrlValue;
	initial {seedAIn, seedAOut, seedBIn, seedBOut} = 32'h0;
	always #10 clk = ~clk;
	boundary_run_test_engine boundary_run_test_engine_inst (.clk, .rst_b, .tck, .tdi,
		.runSelectedTest, .tapIdle, .ctrlScanSelect, .captureDr, .shiftDr, .aSideDriveEnable_b,
		.bSideDriveEnable_b, .aPinIn, .bPinIn, .seedLoad, .seedAIn, .seedAOut, .seedBIn,
		.seedBOut, .tdo, .aPinOut, .aPinOutEn_b, .bPinOut, .bPinOutEn_b, .coreAIn, .coreBIn,
		.cellAIn, .cellAOut, .cellBIn, .cellBOut, .ctrlValue, .testRunning);
	tap_model tap_model_inst (.tck, .tdi, .runSelectedTest, .tapIdle, .ctrlScanSelect,
		.captureDr, .shiftDr);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, want);
		compares++;
		if (seen !== want) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// reference step: src in, dst out, opposite out
	function automatic logic [23:0] nxt(input logic [2:0] op, input logic ab,
			input logic [7:0] p, m, si, so, oo);
		logic [15:0] w;
		logic [7:0]  t8, d, s8;
		t8 = ab ? `TAPS8_A_TO_B : `TAPS8_B_TO_A;
		w = {so, si};
		w = {w[14:0], ^(w & (ab ? `TAPS16_A_TO_B : `TAPS16_B_TO_A))};
		d = p & ~m;
		s8 = {si[6:0], ^(si & t8)} ^ d;
		case (op)
			3'h0, 3'h4: return {p, ~so, oo};
			3'h1, 3'h5: return {w[7:0], w[15:8], oo};
			3'h2, 3'h6: return {w[7:0] ^ d, w[15:8], oo};
			3'h3: return {s8, so[6:0], ^(so & t8), oo};
			default: return {s8, so + 8'h01, oo + {7'h00, so == 8'hFF}};
		endcase
	endfunction
	function automatic logic [23:0] cells();
		return ab ? {cellAIn, cellBOut, cellAOut} : {cellBIn, cellAOut, cellBOut};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		check(ctrlValue, `CTRL_RESET);
		for (int k = 0; k < 16; k++) begin
			op = k[2:0];
			ab = k[3];
			{aSideDriveEnable_b, bSideDriveEnable_b} = {ab, ~ab};
			// zero seed on both 101 pattern runs, one per direction, shows the lock-up
			{seedAIn, seedAOut, seedBIn, seedBOut} = (op == 3'h5) ? 32'h0 : 32'h5AFEC3FF;
			seedLoad = 1'b1;
			#20 seedLoad = 1'b0;
			si = ab ? seedAIn : seedBIn;
			so = ab ? seedBOut : seedAOut;
			oo = ab ? seedAOut : seedBOut;
			tap_model_inst.load({8'h81, op});
			check(ctrlValue, {8'h81, op});
			check(tdo, op[0]);
			check({aPinOutEn_b, bPinOutEn_b}, {ab, ~ab});
			for (int t = 0; t < 3; t++) begin
				aPinIn = 8'h96 ^ {k[3:0], t[3:0]};
				bPinIn = ~aPinIn;
				e = nxt(op, ab, ab ? aPinIn : bPinIn, 8'h81, si, so, oo);
				tap_model_inst.run(1'b1);
				#40;
				{si, so, oo} = e;
				pa = (op[1:0] != 2'h2 && !ab) ? so : pa;
				pb = (op[1:0] != 2'h2 && ab) ? so : pb;
				check(cells(), e);
				check(ab ? bPinOut : aPinOut, ab ? pb : pa);
				check(ab ? coreAIn : coreBIn, si);
			end
		end
		{aSideDriveEnable_b, bSideDriveEnable_b} = 2'h3;
		tap_model_inst.run(1'b1);
		#40;
		check(cells(), e);
		{aSideDriveEnable_b, bSideDriveEnable_b} = 2'h2;
		tap_model_inst.run(1'b0);
		#40;
		check({testRunning, cells()}, {1'b0, e});
		tally_and_finish();
	end
	// a hung handshake would otherwise stall the run for ever
	initial begin
		#200000;
		mismatches++;
		tally_and_finish();
	end
endmodule
bind boundary_run_test_engine boundary_run_test_engine_properties props (.clk, .rst_b, .tck,
	.seedLoad, .aPinOutEn_b, .bPinOutEn_b, .tdo, .aPinOut, .bPinOut, .coreAIn, .cellAIn,
	.cellAOut, .cellBIn, .cellBOut, .ctrlValue, .testRunning);
`default_nettype wire
